/* pkg/analog_in_defs.svh */
// constants for the analogue input scaling and signal-loss supervisor
// assumes samples come in 0.1 V steps (voltage) and 0.1 mA steps (current)
`ifndef ANALOG_IN_DEFS_SVH
`define ANALOG_IN_DEFS_SVH

// -------------------------------------------------------------
// scaling points, in 0.1 V or 0.1 mA steps
// -------------------------------------------------------------
`define VOLT_FULL_CODE   8'h64
`define VOLT_LOW_DEF     8'h00
`define VOLT_HIGH_DEF    8'h64
`define CURR_FULL_CODE   8'hC8
`define CURR_LOW_DEF     8'h28
`define CURR_HIGH_DEF    8'hC8
`define VOLT_LZ_MIN      8'h0A
`define CURR_LZ_MIN      8'h14

// -------------------------------------------------------------
// signal-loss timing
// -------------------------------------------------------------
`define CORE_CLK_HZ      25000000
`define TIMEOUT_SEC_MIN  7'h01
`define TIMEOUT_SEC_MAX  7'h63
`define TIMEOUT_SEC_DEF  7'h0A

// -------------------------------------------------------------
// thermistor divider: sensor to +10 V, pull-down inside
// -------------------------------------------------------------
`define THERM_CUTOUT_OHMS   3000
`define THERM_PULLDOWN_OHMS 10000
`define THERM_TRIP_CODE \
    8'(100 * `THERM_PULLDOWN_OHMS / \
       (`THERM_PULLDOWN_OHMS + `THERM_CUTOUT_OHMS))

`endif

/* pkg/analog_in_pkg.sv */
// types shared by the analogue input supervisor
// assumes analog_in_defs.svh sits on the include path
package analog_in_pkg;

    // input function selection
    typedef enum logic [1:0] {
        FN_NONE  = 2'b00,
        FN_REF   = 2'b01,
        FN_FB    = 2'b10,
        FN_THERM = 2'b11
    } in_func_e;

    // fallback after signal loss
    typedef enum logic [2:0] {
        ACT_NONE      = 3'b000,
        ACT_HOLD      = 3'b001, // hold_output_speed
        ACT_STOP      = 3'b010,
        ACT_JOG       = 3'b011,
        ACT_MAX       = 3'b100,
        ACT_STOP_TRIP = 3'b101
    } loss_action_e;

    // one input's configuration
    typedef struct packed {
        in_func_e    func;
        logic [7:0]  low_point;
        logic [7:0]  high_point;
    } in_cfg_s;

    // floor and ceiling of reference or feedback
    typedef struct packed {
        logic [15:0] floor;
        logic [15:0] ceiling;
    } range_s;

endpackage

/* src/analog_in_supervisor.sv */
// analogue input scaling, summing and signal-loss supervisor
// assumes sample codes arrive asynchronously from a converter; all
// configuration ports come from logic on i_core_clk
`timescale 1ns/1ps
`include "analog_in_defs.svh"

module analog_in_supervisor #(
    parameter int TICKS_PER_SEC = `CORE_CLK_HZ
) (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_ce,
    input  wire logic [7:0]                  i_volt_a_sample,
    input  wire logic [7:0]                  i_volt_b_sample,
    input  wire logic [7:0]                  i_curr_sample,
    input  wire logic                        i_cfg_load,
    input  wire logic                        i_factory_reset,
    input  wire analog_in_pkg::in_cfg_s      i_volt_in_a_cfg,
    input  wire analog_in_pkg::in_cfg_s      i_volt_in_b_cfg,
    input  wire analog_in_pkg::in_cfg_s      i_curr_in_cfg,
    input  wire logic [6:0]                  i_signal_loss_timeout,
    input  wire analog_in_pkg::loss_action_e i_signal_loss_action,
    input  wire analog_in_pkg::range_s       i_reference,
    input  wire analog_in_pkg::range_s       i_feedback,
    input  wire logic                        i_bus_timeout,
    input  wire logic                        i_trip_ack,
    output logic [17:0]                      o_reference_total,
    output logic [17:0]                      o_feedback_total,
    output logic [2:0]                       o_signal_loss,
    output analog_in_pkg::loss_action_e      o_fallback_action,
    output logic                             o_motor_stop,
    output logic                             o_trip,
    output logic                             o_therm_hot,
    output logic                             o_bus_action_go
);
    import analog_in_pkg::*;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // linear map of a clamped sample onto floor..ceiling
    function automatic logic [17:0] scale_in(
        input logic [7:0] x,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input range_s     r
    );
        logic [7:0]  xc;
        logic [15:0] span;
        logic [31:0] num;
        xc   = (x < lo) ? lo : ((x > hi) ? hi : x);
        span = r.ceiling - r.floor;
        num  = 32'(xc - lo) * 32'(span);
        // flat or inverted points fall back to the floor
        if (hi <= lo) begin
            scale_in = {2'b00, r.floor};
        end else begin
            scale_in = 18'(r.floor) + 18'(num / 32'(hi - lo));
        end
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    in_cfg_s      cfg_reg [3];    // 0 volt a, 1 volt b, 2 current
    in_cfg_s      cfg_next [3];
    logic [7:0]   smp_meta_reg [3]; // first synchroniser stage
    logic [7:0]   smp_reg [3];      // second stage, safe to read
    logic [6:0]   timeout_reg;
    loss_action_e action_reg;
    logic [24:0]  tick_cnt_reg;
    logic [6:0]   secs_reg [3];
    logic [6:0]   secs_next [3];
    logic [2:0]   loss_next;

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    wire        sec_tick = (tick_cnt_reg == 25'(TICKS_PER_SEC - 1));
    wire [17:0] ref_part [3];
    wire [17:0] fb_part  [3];
    wire [2:0]  lz_armed;        // supervision enabled per input
    wire [2:0]  lz_below;        // under half the low point
    wire [6:0]  timeout_clamped =
        (i_signal_loss_timeout < `TIMEOUT_SEC_MIN) ? `TIMEOUT_SEC_MIN :
        (i_signal_loss_timeout > `TIMEOUT_SEC_MAX) ? `TIMEOUT_SEC_MAX :
        i_signal_loss_timeout;

    for (genvar g = 0; g < 3; g++) begin : g_in
        // an unused input drops out of both sums
        assign ref_part[g] = (cfg_reg[g].func == FN_REF) ?
            scale_in(smp_reg[g], cfg_reg[g].low_point,
                     cfg_reg[g].high_point, i_reference) : 18'h0_0000;
        assign fb_part[g] = (cfg_reg[g].func == FN_FB) ?
            scale_in(smp_reg[g], cfg_reg[g].low_point,
                     cfg_reg[g].high_point, i_feedback) : 18'h0_0000;
        // only live-zero capable low points are watched
        assign lz_armed[g] =
            ((cfg_reg[g].func == FN_REF) || (cfg_reg[g].func == FN_FB))
            && (cfg_reg[g].low_point >
                ((g == 2) ? `CURR_LZ_MIN : `VOLT_LZ_MIN));
        // 2*x < low means below fifty percent
        assign lz_below[g] = ({smp_reg[g], 1'b0} < {1'b0,
                              cfg_reg[g].low_point});
        // any recovery or disarm restarts the count
        assign secs_next[g] = !(lz_armed[g] && lz_below[g]) ? 7'h00 :
            (sec_tick && secs_reg[g] != 7'h7F) ? secs_reg[g] + 7'h01 :
            secs_reg[g];
        // declared only when longer than the time-out
        assign loss_next[g] = lz_armed[g] && lz_below[g] &&
                              (secs_next[g] > timeout_reg);
    end

    // sums of all contributions
    wire [17:0] ref_sum = ref_part[0] + ref_part[1] + ref_part[2];
    wire [17:0] fb_sum  = fb_part[0] + fb_part[1] + fb_part[2];
    wire        any_loss = |loss_next;

    // thermistor on voltage inputs only; high ohms pull the code low
    wire therm_hot_w =
        ((cfg_reg[0].func == FN_THERM) &&
         (smp_reg[0] < `THERM_TRIP_CODE)) ||
        ((cfg_reg[1].func == FN_THERM) &&
         (smp_reg[1] < `THERM_TRIP_CODE));

    wire stop_act = (action_reg == ACT_STOP) ||
                    (action_reg == ACT_STOP_TRIP);

    // next configuration: factory values win over a load
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            cfg_next[k] = cfg_reg[k];
        end
        if (i_factory_reset) begin
            cfg_next[0] = '{FN_REF, `VOLT_LOW_DEF, `VOLT_HIGH_DEF};
            cfg_next[1] = '{FN_NONE, `VOLT_LOW_DEF, `VOLT_HIGH_DEF};
            cfg_next[2] = '{FN_REF, `CURR_LOW_DEF, `CURR_HIGH_DEF};
        end else if (i_cfg_load) begin
            cfg_next[0] = i_volt_in_a_cfg;
            cfg_next[1] = i_volt_in_b_cfg;
            cfg_next[2] = i_curr_in_cfg;
            // current input cannot carry a thermistor
            if (i_curr_in_cfg.func == FN_THERM) begin
                cfg_next[2].func = FN_NONE;
            end
        end
    end

    // -------------------------------------------------------------
    // configuration and synchroniser
    // -------------------------------------------------------------
    // defaults: low 0 V / 4 mA, high 10 V / 20 mA
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_reg[0]  <= '{FN_REF, `VOLT_LOW_DEF, `VOLT_HIGH_DEF};
            cfg_reg[1]  <= '{FN_NONE, `VOLT_LOW_DEF, `VOLT_HIGH_DEF};
            cfg_reg[2]  <= '{FN_REF, `CURR_LOW_DEF, `CURR_HIGH_DEF};
            timeout_reg <= `TIMEOUT_SEC_DEF;
            action_reg  <= ACT_NONE;
            for (int k = 0; k < 3; k++) begin
                smp_meta_reg[k] <= 8'h00;
                smp_reg[k]      <= 8'h00;
            end
        end else if (i_ce) begin
            cfg_reg <= cfg_next;
            if (i_factory_reset) begin
                timeout_reg <= `TIMEOUT_SEC_DEF;
                action_reg  <= ACT_NONE;
            end else if (i_cfg_load) begin
                timeout_reg <= timeout_clamped;
                action_reg  <= i_signal_loss_action;
            end
            smp_meta_reg[0] <= i_volt_a_sample;
            smp_meta_reg[1] <= i_volt_b_sample;
            smp_meta_reg[2] <= i_curr_sample;
            smp_reg         <= smp_meta_reg;
        end
    end

    // -------------------------------------------------------------
    // one-second prescaler and loss timers
    // -------------------------------------------------------------
    // free running; first counted second may be short by up to TICKS_PER_SEC - 1 ticks
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_reg <= 25'h000_0000;
            for (int k = 0; k < 3; k++) begin
                secs_reg[k] <= 7'h00;
            end
        end else if (i_ce) begin
            tick_cnt_reg <= sec_tick ? 25'h000_0000 :
                            tick_cnt_reg + 25'h000_0001;
            secs_reg     <= secs_next;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reference_total <= 18'h0_0000;
            o_feedback_total  <= 18'h0_0000;
            o_signal_loss     <= 3'h0;
            o_fallback_action <= ACT_NONE;
            o_motor_stop      <= 1'b0;
            o_trip            <= 1'b0;
            o_therm_hot       <= 1'b0;
            o_bus_action_go   <= 1'b0;
        end else if (i_ce) begin
            o_reference_total <= ref_sum;
            o_feedback_total  <= fb_sum;
            o_signal_loss     <= loss_next;
            // fallback stands while any loss persists
            o_fallback_action <= any_loss ? action_reg : ACT_NONE;
            o_motor_stop      <= therm_hot_w ||
                                 (any_loss && stop_act);
            // sticky trip; a new trip beats the acknowledge
            o_trip <= (any_loss && action_reg == ACT_STOP_TRIP) ||
                      (o_trip && !i_trip_ack);
            o_therm_hot       <= therm_hot_w;
            // bus time-out yields to a signal loss
            o_bus_action_go   <= i_bus_timeout && !any_loss;
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    sequence loss_seen;
        i_ce && any_loss;
    endsequence

    sequence input_ok (int n);
        i_ce && !(lz_armed[n] && lz_below[n]);
    endsequence

    noop_ignored_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && cfg_reg[0].func == FN_NONE &&
        cfg_reg[1].func == FN_NONE && cfg_reg[2].func == FN_NONE
        |=> o_reference_total == 18'h0_0000)
        else $error("no-op inputs reached the reference");

    ref_sum_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce |=> o_reference_total ==
        $past(ref_part[0] + ref_part[1] + ref_part[2]))
        else $error("reference total is not the sum");

    therm_stop_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && therm_hot_w
        |=> o_motor_stop && o_therm_hot)
        else $error("hot thermistor did not stop motor");

    factory_cfg_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && i_factory_reset
        |=> cfg_reg[1].func == FN_NONE && cfg_reg[2].func == FN_REF)
        else $error("factory functions wrong");

    factory_pts_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && i_factory_reset
        |=> cfg_reg[2].low_point == `CURR_LOW_DEF &&
            cfg_reg[2].high_point == `CURR_HIGH_DEF &&
            cfg_reg[0].low_point == `VOLT_LOW_DEF &&
            cfg_reg[0].high_point == `VOLT_HIGH_DEF)
        else $error("factory scaling points wrong");

    // the flag lags the sample by one edge, so look back at it
    loss_time_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && o_signal_loss[0]
        |-> secs_reg[0] > timeout_reg && $past(lz_below[0]))
        else $error("loss flagged before time-out");

    loss_arm_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && o_signal_loss[2]
        |-> cfg_reg[2].low_point > `CURR_LZ_MIN)
        else $error("current loss with low point too small");

    loss_act_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) loss_seen
        |=> o_fallback_action == $past(action_reg))
        else $error("fallback action not applied");

    bus_prio_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) loss_seen and i_bus_timeout
        |=> !o_bus_action_go)
        else $error("bus action ran during signal loss");

    // watch input a, the one that actually dips and recovers
    timer_restart_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) input_ok(0) |=> secs_reg[0] == 7'h00)
        else $error("loss timer not restarted");

    // a thermistor request on the current input is never kept
    curr_no_therm_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) cfg_reg[2].func != FN_THERM)
        else $error("current input holds thermistor function");

    // a latched trip only drops on an acknowledge
    trip_hold_a: assert property (@(posedge i_core_clk)
        disable iff (i_rst) i_ce && o_trip && !i_trip_ack |=> o_trip)
        else $error("trip dropped without acknowledge");

endmodule

/* tb/analog_source.sv */
// far-side sources: two voltage lines, one current loop, thermistor
// assumes codes are 0.1 V or 0.1 mA steps, converter runs on its own
`timescale 1ns/1ps
module analog_source (
    input  wire logic        i_therm_on,
    input  wire logic [15:0] i_therm_ohms,
    input  wire logic [7:0]  i_level_a,
    input  wire logic [7:0]  i_level_b,
    input  wire logic [7:0]  i_level_c,
    output logic [7:0]       o_volt_a,
    output logic [7:0]       o_volt_b,
    output logic [7:0]       o_curr
);
    logic [7:0] therm_code; // divider result, sensor to +10 V
    // -------------------------------------------------------------
    // thermistor divider against the 10 kohm pull-down inside
    // -------------------------------------------------------------
    assign therm_code = 8'(32'h000F_4240 /
        (32'h0000_2710 + 32'(i_therm_ohms)));
    // converter lags the clock by an unrelated few ns
    assign #3 o_volt_a = i_level_a;
    assign #3 o_volt_b = i_therm_on ? therm_code : i_level_b;
    assign #3 o_curr   = i_level_c;
endmodule

/* tb/test_analog_in_supervisor.sv */
// bench for analog_in_supervisor: scaling, sums, thermistor, loss
// assumes analog_source drives the sample pins; seconds shortened
`timescale 1ns/1ps
module test_analog_in_supervisor;
    import analog_in_pkg::*;
    localparam int TPS = 10; // clock ticks per simulated second
    logic         i_core_clk = 1'b0;
    logic         i_rst      = 1'b1;
    logic         i_ce       = 1'b1;
    logic         i_cfg_load = 1'b0;
    logic         i_factory_reset = 1'b0;
    logic         i_bus_timeout = 1'b0;
    logic         i_trip_ack = 1'b0;
    logic [6:0]   to_sec     = 7'h02;
    loss_action_e act        = ACT_NONE;
    in_cfg_s      cfg_a, cfg_b, cfg_c;
    range_s       ref_r, fb_r;
    logic [7:0]   lvl_a = 8'h00, lvl_b = 8'h00, lvl_c = 8'h00;
    logic         therm_on   = 1'b0;
    logic [15:0]  ohms       = 16'h0000;
    logic [7:0]   smp_a, smp_b, smp_c;
    logic [17:0]  ref_tot, fb_tot;
    logic [2:0]   loss;
    loss_action_e fall_act;
    logic         stop, trip, hot, bus_go;
    int           fail_count = 0;
    int           samples_checked = 0;

    always #20 i_core_clk = ~i_core_clk;

    analog_source SRC (.i_therm_on(therm_on), .i_therm_ohms(ohms),
        .i_level_a(lvl_a), .i_level_b(lvl_b), .i_level_c(lvl_c),
        .o_volt_a(smp_a), .o_volt_b(smp_b), .o_curr(smp_c));

    analog_in_supervisor #(.TICKS_PER_SEC(TPS)) DUT (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_volt_a_sample(smp_a), .i_volt_b_sample(smp_b),
        .i_curr_sample(smp_c), .i_cfg_load(i_cfg_load),
        .i_factory_reset(i_factory_reset), .i_volt_in_a_cfg(cfg_a),
        .i_volt_in_b_cfg(cfg_b), .i_curr_in_cfg(cfg_c),
        .i_signal_loss_timeout(to_sec), .i_signal_loss_action(act),
        .i_reference(ref_r), .i_feedback(fb_r),
        .i_bus_timeout(i_bus_timeout), .i_trip_ack(i_trip_ack),
        .o_reference_total(ref_tot), .o_feedback_total(fb_tot),
        .o_signal_loss(loss), .o_fallback_action(fall_act),
        .o_motor_stop(stop), .o_trip(trip), .o_therm_hot(hot),
        .o_bus_action_go(bus_go));

    // -------------------------------------------------------------
    // shared helpers
    // -------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    // one comparison, four-state exact
    task automatic chk(input string nm, input logic [17:0] e, g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // one-cycle load pulse, then let cfg reach the outputs
    task automatic pulse_load;
        i_cfg_load = 1'b1;
        cyc(1);
        i_cfg_load = 1'b0;
        cyc(4);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    // factory config: a and current add, b ignored, default points
    task automatic t_factory;
        lvl_a = 8'h32; lvl_b = 8'h64; lvl_c = 8'h78;
        cyc(6);
        chk("ref_sum", 18'h0_03E8, ref_tot);
        chk("fb_sum", 18'h0_0000, fb_tot);
        lvl_a = 8'h64; lvl_c = 8'hC8;
        cyc(6);
        chk("ref_top", 18'h0_07D0, ref_tot);
        lvl_a = 8'h00; lvl_c = 8'h28;
        cyc(6);
        chk("ref_low", 18'h0_0000, ref_tot);
    endtask
    // two voltage feedbacks, custom points, clamp above high point
    task automatic t_scale;
        cfg_a = '{FN_FB, 8'h14, 8'h50};
        cfg_b = '{FN_FB, 8'h00, 8'h64};
        cfg_c = '{FN_NONE, 8'h28, 8'hC8};
        pulse_load;
        lvl_a = 8'h32; lvl_b = 8'h32; lvl_c = 8'hC8;
        cyc(6);
        chk("fb_mid", 18'h0_0320, fb_tot);
        chk("ref_none", 18'h0_0000, ref_tot);
        lvl_a = 8'h5A;
        cyc(6);
        chk("fb_clamp", 18'h0_044C, fb_tot);
    endtask
    // thermistor on b: cold below cut-out, stops motor above
    task automatic t_therm;
        cfg_b = '{FN_THERM, 8'h00, 8'h64};
        cfg_c = '{FN_THERM, 8'h28, 8'hC8}; // must be refused
        pulse_load;
        therm_on = 1'b1; ohms = 16'h09C4;
        cyc(6);
        chk("hot_cold", 18'h0_0000, {17'h0_0000, hot});
        ohms = 16'h0DAC;
        cyc(6);
        chk("hot_hot", 18'h0_0001, {17'h0_0000, hot});
        chk("stop_hot", 18'h0_0001, {17'h0_0000, stop});
        therm_on = 1'b0;
    endtask
    // drop below half of low point, each fallback code in turn
    task automatic t_loss(input loss_action_e a);
        int k;
        cfg_a = '{FN_REF, 8'h14, 8'h64};
        cfg_b = '{FN_NONE, 8'h00, 8'h64};
        act = a;
        pulse_load;
        lvl_a = 8'h32;
        cyc(5);
        lvl_a = 8'h09;
        cyc(18);
        chk("loss_early", 18'h0_0000, {15'h0000, loss});
        for (k = 0; k < 20 && loss[0] !== 1'b1; k++)
            cyc(1);
        chk("loss_set", 18'h0_0001, {15'h0000, loss});
        chk("fall_act", {15'h0000, a}, {15'h0000, fall_act});
        chk("stop", {17'h0_0000, a == ACT_STOP || a == ACT_STOP_TRIP},
            {17'h0_0000, stop});
        chk("trip", {17'h0_0000, a == ACT_STOP_TRIP},
            {17'h0_0000, trip});
        i_bus_timeout = 1'b1;
        cyc(2);
        chk("bus_lost", 18'h0_0000, {17'h0_0000, bus_go});
        lvl_a = 8'h32;
        cyc(5);
        chk("loss_clear", 18'h0_0000, {15'h0000, loss});
        chk("trip_hold", {17'h0_0000, a == ACT_STOP_TRIP},
            {17'h0_0000, trip});
        chk("bus_go", 18'h0_0001, {17'h0_0000, bus_go});
        i_bus_timeout = 1'b0;
        i_trip_ack = 1'b1;
        cyc(1);
        i_trip_ack = 1'b0;
        cyc(2);
        chk("trip_ack", 18'h0_0000, {17'h0_0000, trip});
    endtask
    // brief recovery at exactly half restarts the timer
    task automatic t_restart;
        lvl_a = 8'h09;
        cyc(15);
        lvl_a = 8'h0A;
        cyc(4);
        lvl_a = 8'h09;
        cyc(18);
        chk("restart", 18'h0_0000, {15'h0000, loss});
        lvl_a = 8'h32;
        cyc(5);
    endtask
    // low point 1 V not supervised; current 2.1 mA is
    task automatic t_armed;
        cfg_a = '{FN_REF, 8'h0A, 8'h64};
        cfg_c = '{FN_REF, 8'h15, 8'hC8};
        to_sec = 7'h01;
        act = ACT_NONE;
        pulse_load;
        lvl_a = 8'h00; lvl_c = 8'h0A;
        cyc(30);
        chk("armed", 18'h0_0004, {15'h0000, loss});
        lvl_c = 8'h78;
    endtask
    // all inputs idle, factory defaults back, then enable held low
    task automatic t_refactory;
        cfg_a.func = FN_NONE;
        cfg_c.func = FN_NONE;
        pulse_load;
        chk("ref_noop", 18'h0_0000, ref_tot);
        chk("fb_noop", 18'h0_0000, fb_tot);
        i_factory_reset = 1'b1;
        cyc(1);
        i_factory_reset = 1'b0;
        lvl_a = 8'h32; lvl_b = 8'h64; lvl_c = 8'h78;
        cyc(6);
        chk("ref_fact", 18'h0_03E8, ref_tot);
        i_ce = 1'b0;
        lvl_a = 8'h00;
        cyc(6);
        chk("ref_frozen", 18'h0_03E8, ref_tot);
        i_ce = 1'b1;
        cyc(6);
        chk("ref_thaw", 18'h0_01F4, ref_tot);
    endtask

    // -------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------
    initial begin
        cfg_a = '{FN_REF, 8'h00, 8'h64};
        cfg_b = '{FN_NONE, 8'h00, 8'h64};
        cfg_c = '{FN_REF, 8'h28, 8'hC8};
        ref_r = '{16'h0000, 16'h03E8};
        fb_r  = '{16'h0064, 16'h02BC};
        cyc(3);
        i_rst = 1'b0;
        cyc(1);
        t_factory;
        t_scale;
        t_therm;
        for (int c = 0; c < 6; c++)
            t_loss(loss_action_e'(c));
        t_restart;
        t_armed;
        t_refactory;
        stop_test;
    end
    // whole run needs under 1000 cycles; far beyond that is a hang
    initial begin
        repeat (4000) @(posedge i_core_clk);
        fail_count++;
        stop_test;
    end
endmodule
